// *** src/program_download_sequencer.sv ***
`timescale 1ns/100ps
`include "pd_defs.svh"
module program_download_sequencer #(
   parameter int TRANS_CYCLES = `TRANS_MS * `CLK_KHZ,
   parameter int RSP_CYCLES   = `RSP_WAIT_MS * `CLK_KHZ,
   parameter logic [15:0] MAX_DOWNLOAD_SIZE = `MAX_DL_SIZE
) (
   // Clock and reset
   input  wire logic            mclk_i,
   input  wire logic            srst_i,
   // Control
   input  wire logic            start_i,
   input  wire logic            peer_flag_i,
   input  wire logic            retain_flag_i,
   input  wire logic [31:0]     maker_code_i,
   // Parsed response
   input  wire logic            rsp_valid_i,
   input  wire pd_pkg::rsp_t    rsp_i,
   // Request out
   output logic                 req_valid_o,
   output pd_pkg::req_t         req_o,
   // Completion notification out
   output logic                 notify_valid_o,
   output pd_pkg::notify_t      notify_o,
   // Status
   output logic                 err_o,
   output logic                 discard_o,
   output logic                 busy_o
);
   pd_pkg::state_t    state;
   logic [1:0]        retries;
   logic [7:0]        cur_fn;
   logic [7:0]        cur_seq;
   logic              sw_same_held;
   logic              ok_flag;
   logic              tmr_exp;
   logic              tmr_load;
   logic [`TMR_W-1:0] tmr_count;
   logic              in_wait;
   logic              fn_bad;
   logic              fail;
   logic              data_bad;
   logic              good;

   always_comb begin
      tmr_load  = 1'b0;
      tmr_count = `TMR_W'(RSP_CYCLES);
      if (state == pd_pkg::ST_IDLE && start_i) begin
         tmr_load  = 1'b1;
         tmr_count = `TMR_W'(TRANS_CYCLES);
      end else if (state == pd_pkg::ST_SEND) begin
         tmr_load = 1'b1;
      end
   end

   wait_timer u_timer (
      .mclk_i    (mclk_i),
      .srst_i    (srst_i),
      .load_i    (tmr_load),
      .count_i   (tmr_count),
      .expired_o (tmr_exp)
   );

   always_comb begin
      in_wait  = (state == pd_pkg::ST_WAIT);
      fn_bad   = (rsp_i.frame_number != `FN_NONE) && (rsp_i.frame_number != cur_fn);
      fail     = in_wait && (tmr_exp || (rsp_valid_i && (!rsp_i.fcc_ok || fn_bad)));
      data_bad = in_wait && rsp_valid_i && !fail &&
                 ((rsp_i.data_size > MAX_DOWNLOAD_SIZE) ||
                  (rsp_i.maker != maker_code_i) ||
                  ((cur_seq == `SEQ_ENV) && (rsp_i.env_id != `OWN_ENV)));
      good     = in_wait && rsp_valid_i && !fail && !data_bad;
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state <= pd_pkg::ST_IDLE;
      end else begin
         case (state)
            pd_pkg::ST_IDLE: begin
               if (start_i) begin
                  state <= (peer_flag_i && retain_flag_i) ? pd_pkg::ST_TRANS : pd_pkg::ST_SEND;
               end
            end
            pd_pkg::ST_TRANS: begin
               if (tmr_exp) begin
                  state <= pd_pkg::ST_SEND;
               end
            end
            pd_pkg::ST_SEND: begin
               state <= pd_pkg::ST_WAIT;
            end
            pd_pkg::ST_WAIT: begin
               if (fail) begin
                  state <= (retries == `RETRY_LIMIT) ? pd_pkg::ST_NOTIFY : pd_pkg::ST_SEND;
               end else if (data_bad) begin
                  state <= pd_pkg::ST_NOTIFY;
               end else if (good) begin
                  if ((cur_seq == `SEQ_ENV && sw_same_held) || (cur_seq > `SEQ_ENV && rsp_i.last)) begin
                     state <= pd_pkg::ST_NOTIFY;
                  end else begin
                     state <= pd_pkg::ST_SEND;
                  end
               end
            end
            pd_pkg::ST_NOTIFY: begin
               state <= pd_pkg::ST_IDLE;
            end
            default: begin
               state <= pd_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Retry count per frame
   always_ff @(posedge mclk_i) begin
      if (srst_i || state == pd_pkg::ST_IDLE) begin
         retries <= `RETRY_ZERO;
      end else if (good) begin
         retries <= `RETRY_ZERO;
      end else if (fail && retries != `RETRY_LIMIT) begin
         retries <= retries + 2'h1;
      end
   end

   // Frame and sequence numbering; retransmits keep both
   always_ff @(posedge mclk_i) begin
      if (srst_i || state == pd_pkg::ST_IDLE) begin
         cur_fn  <= `FN_FIRST;
         cur_seq <= `SEQ_SW;
      end else if (good) begin
         cur_fn  <= (cur_fn == `FN_LAST) ? `FN_FIRST : cur_fn + 8'h01;
         cur_seq <= cur_seq + 8'h01;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i || state == pd_pkg::ST_IDLE) begin
         sw_same_held <= 1'b0;
      end else if (good && cur_seq == `SEQ_SW) begin
         sw_same_held <= rsp_i.sw_same;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i || state == pd_pkg::ST_IDLE) begin
         ok_flag <= 1'b0;
      end else if (good) begin
         ok_flag <= 1'b1;
      end else if (fail || data_bad) begin
         ok_flag <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         req_valid_o <= 1'b0;
         req_o       <= '0;
      end else begin
         req_valid_o <= (state == pd_pkg::ST_SEND);
         req_o       <= '{frame_number: cur_fn, seq: cur_seq};
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         notify_valid_o <= 1'b0;
         notify_o       <= '0;
      end else begin
         notify_valid_o <= (state == pd_pkg::ST_NOTIFY);
         notify_o       <= '{command_code: `CMD_NOTIFY, length: `NOTIFY_LEN,
                             first_payload_byte: ok_flag ? `RES_OK : `RES_FAIL};
      end
   end

   // Error indicator holds until the next start; set wins
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         err_o <= 1'b0;
      end else if (data_bad || (fail && retries == `RETRY_LIMIT)) begin
         err_o <= 1'b1;
      end else if (state == pd_pkg::ST_IDLE && start_i) begin
         err_o <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         discard_o <= 1'b0;
         busy_o    <= 1'b0;
      end else begin
         discard_o <= data_bad;
         busy_o    <= (state != pd_pkg::ST_IDLE) || start_i;
      end
   end

   logic [`TMR_W-1:0] trans_cnt;
   always_ff @(posedge mclk_i) begin
      if (srst_i || state != pd_pkg::ST_TRANS) begin
         trans_cnt <= '0;
      end else if (trans_cnt != '1) begin
         trans_cnt <= trans_cnt + `TMR_W'(1);
      end
   end

   AST_TRANS_MIN: assert property (@(posedge mclk_i) disable iff (srst_i)
      (state == pd_pkg::ST_TRANS && tmr_exp) |-> (trans_cnt >= `TMR_W'(TRANS_CYCLES)))
      else $error("transition wait too short");
   AST_TRANS_ENTRY: assert property (@(posedge mclk_i) disable iff (srst_i)
      (state == pd_pkg::ST_IDLE && start_i && peer_flag_i && retain_flag_i) |=> state == pd_pkg::ST_TRANS)
      else $error("transition wait skipped");
   AST_TIMEOUT_FAIL: assert property (@(posedge mclk_i) disable iff (srst_i)
      (in_wait && tmr_exp && retries != `RETRY_LIMIT) |=> state == pd_pkg::ST_SEND ##1 req_valid_o)
      else $error("timeout did not retransmit");
   AST_ERR_HOLD: assert property (@(posedge mclk_i) disable iff (srst_i)
      (err_o && !(state == pd_pkg::ST_IDLE && start_i)) |=> err_o)
      else $error("error indicator dropped");
   AST_RETRY_SAME_FN: assert property (@(posedge mclk_i) disable iff (srst_i)
      (fail && retries != `RETRY_LIMIT) |-> ##2 req_valid_o && req_o.frame_number == $past(cur_fn, 2))
      else $error("retransmit changed frame number");
   AST_RETRY_LIMIT: assert property (@(posedge mclk_i) disable iff (srst_i)
      (fail && retries == `RETRY_LIMIT) |=> err_o ##1 notify_valid_o && notify_o.first_payload_byte == `RES_FAIL)
      else $error("retry limit not enforced");
   AST_FN_BAD: assert property (@(posedge mclk_i) disable iff (srst_i)
      (in_wait && rsp_valid_i && rsp_i.frame_number != `FN_NONE && rsp_i.frame_number != cur_fn) |=> !discard_o && !ok_flag)
      else $error("wrong frame number accepted");
   AST_DATA_BAD: assert property (@(posedge mclk_i) disable iff (srst_i)
      (in_wait && rsp_valid_i && !fail && (rsp_i.data_size > MAX_DOWNLOAD_SIZE || rsp_i.maker != maker_code_i))
      |=> discard_o && err_o && state == pd_pkg::ST_NOTIFY)
      else $error("bad download data not discarded");
   AST_SKIP: assert property (@(posedge mclk_i) disable iff (srst_i)
      (good && cur_seq == `SEQ_ENV && sw_same_held) |=> ##1 notify_valid_o && notify_o.first_payload_byte == `RES_OK)
      else $error("skip did not notify success");
   AST_NOTIFY_LEN: assert property (@(posedge mclk_i) disable iff (srst_i)
      notify_valid_o |-> notify_o.length == `NOTIFY_LEN && notify_o.command_code == `CMD_NOTIFY)
      else $error("bad notification length");
   AST_RETRY_CLR: assert property (@(posedge mclk_i) disable iff (srst_i)
      good |=> retries == `RETRY_ZERO)
      else $error("retry count not cleared");

   COV_RETRY: cover property (@(posedge mclk_i) disable iff (srst_i) fail ##[1:50] good);
   COV_EXHAUST: cover property (@(posedge mclk_i) disable iff (srst_i) fail && retries == `RETRY_LIMIT);
   COV_SKIP: cover property (@(posedge mclk_i) disable iff (srst_i) good && cur_seq == `SEQ_ENV && sw_same_held);
   COV_FULL: cover property (@(posedge mclk_i) disable iff (srst_i)
      notify_valid_o && notify_o.first_payload_byte == `RES_OK && !sw_same_held);
endmodule // program_download_sequencer

// *** src/pd_defs.svh ***
`ifndef PD_DEFS_SVH
`define PD_DEFS_SVH
`define CLK_KHZ     10000
`define TRANS_MS    500
`define RSP_WAIT_MS 300
`define TMR_W       23
`define RETRY_LIMIT 2'h3
`define RETRY_ZERO  2'h0
`define FN_NONE     8'h00
`define FN_FIRST    8'h01
`define FN_LAST     8'hFF
`define MAX_DL_SIZE 16'h0400
`define SEQ_SW      8'h00
`define SEQ_ENV     8'h01
`define OWN_ENV     8'h00
`define RES_FAIL    8'h00
`define RES_OK      8'h01
`define NOTIFY_LEN  16'h0001
`define CMD_NOTIFY  8'h01
`endif

// *** src/pd_pkg.sv ***
package pd_pkg;
   typedef struct packed {
      logic [7:0]  frame_number;
      logic        fcc_ok;
      logic [15:0] data_size;
      logic [31:0] maker;
      logic [7:0]  env_id;
      logic        sw_same;
      logic        last;
   } rsp_t;
   typedef struct packed {
      logic [7:0] frame_number;
      logic [7:0] seq;
   } req_t;
   typedef struct packed {
      logic [7:0]  command_code;
      logic [15:0] length;
      logic [7:0]  first_payload_byte;
   } notify_t;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_TRANS  = 3'b001,
      ST_SEND   = 3'b010,
      ST_WAIT   = 3'b011,
      ST_NOTIFY = 3'b100
   } state_t;
endpackage

// *** src/wait_timer.sv ***
`timescale 1ns/100ps
`include "pd_defs.svh"
module wait_timer (
   // Clock and reset
   input  wire logic              mclk_i,
   input  wire logic              srst_i,
   // Control
   input  wire logic              load_i,
   input  wire logic [`TMR_W-1:0] count_i,
   // Status
   output logic                   expired_o
);
   logic [`TMR_W-1:0] cnt;
   logic              run;

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         cnt <= '0;
         run <= 1'b0;
      end else if (load_i) begin
         cnt <= count_i - `TMR_W'(1);
         run <= 1'b1;
      end else if (run) begin
         if (cnt == '0) begin
            run <= 1'b0;
         end else begin
            cnt <= cnt - `TMR_W'(1);
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         expired_o <= 1'b0;
      end else begin
         expired_o <= !load_i && run && (cnt == '0);
      end
   end
endmodule // wait_timer

// *** dv/equip_model.sv ***
`timescale 1ns/100ps
module equip_model (
   // Clock and reset
   input  wire logic         mclk_i,
   input  wire logic         srst_i,
   // Scenario
   input  wire logic [3:0]   dly_i,
   input  wire logic [2:0]   kind_i,
   input  wire logic [2:0]   fail_n_i,
   input  wire logic [7:0]   last_seq_i,
   input  wire logic         sw_same_i,
   input  wire logic [7:0]   env_i,
   input  wire logic [15:0]  size_i,
   input  wire logic [31:0]  maker_i,
   // Request in
   input  wire logic         req_valid_i,
   input  wire pd_pkg::req_t req_i,
   // Response out
   output logic              rsp_valid_o,
   output pd_pkg::rsp_t      rsp_o
);
   pd_pkg::req_t held;
   logic [3:0]   cnt;
   logic         pend;
   logic [2:0]   fails;
   logic [7:0]   seq_prev;
   logic         bad;
   // Kinds: 1 silent, 2 bad check code, 3 wrong number, 4 number zero
   assign bad = (fails < fail_n_i) && (kind_i != 3'h0) && (kind_i != 3'h4);
   always_ff @(posedge mclk_i) begin
      rsp_valid_o <= 1'b0;
      rsp_o       <= ~rsp_o;
      if (srst_i) begin
         pend     <= 1'b0;
         fails    <= 3'h0;
         seq_prev <= 8'hFF;
         rsp_o    <= '0;
      end else if (req_valid_i) begin
         held <= req_i;
         cnt  <= dly_i;
         pend <= 1'b1;
         if (req_i.seq != seq_prev) begin
            fails    <= 3'h0;
            seq_prev <= req_i.seq;
         end
      end else if (pend && cnt == 4'h1) begin
         pend <= 1'b0;
         if (bad) begin
            fails <= fails + 3'h1;
         end
         if (!(bad && kind_i == 3'h1)) begin
            rsp_valid_o <= 1'b1;
            rsp_o <= '{(kind_i == 3'h4) ? 8'h00 : held.frame_number + {7'h0, bad && kind_i == 3'h3},
                       !(bad && kind_i == 3'h2), size_i, maker_i,
                       (held.seq == 8'h01) ? env_i : 8'h00, sw_same_i, held.seq == last_seq_i};
         end
      end else if (pend) begin
         cnt <= cnt - 4'h1;
      end
   end
endmodule // equip_model

// *** dv/program_download_sequencer_tb.sv ***
`timescale 1ns/100ps
`include "pd_defs.svh"
module program_download_sequencer_tb;
   localparam int TRANS = 20;
   localparam int RSPC  = 10;
   logic            mclk_i = 1'b0;
   logic            srst_i = 1'b1;
   logic            start_i = 1'b0;
   logic            peer_flag_i = 1'b0;
   logic            retain_flag_i = 1'b0;
   logic [31:0]     maker_code_i = 32'h0000_1234; // Arbitrary maker code
   logic            rsp_valid_i;
   pd_pkg::rsp_t    rsp_i;
   logic            req_valid_o;
   pd_pkg::req_t    req_o;
   logic            notify_valid_o;
   pd_pkg::notify_t notify_o;
   logic            err_o;
   logic            discard_o;
   logic            busy_o;
   logic [3:0]      m_dly = 4'h3;
   logic [2:0]      m_kind = 3'h0;
   logic [2:0]      m_fail = 3'h0;
   logic [7:0]      m_last = 8'h03;
   logic            m_sw = 1'b0;
   logic [7:0]      m_env = 8'h00;
   logic [15:0]     m_size = 16'h0010;
   logic [31:0]     m_maker = 32'h0000_1234;
   logic [31:0]     seed = 32'hA5B83E9D;
   int              fails = 0;
   int              num_checks = 0;
   int              cycles = 0;

   always #50 mclk_i = ~mclk_i;

   program_download_sequencer #(.TRANS_CYCLES(TRANS), .RSP_CYCLES(RSPC), .MAX_DOWNLOAD_SIZE(16'h0400)) uut (
      .mclk_i(mclk_i), .srst_i(srst_i), .start_i(start_i), .peer_flag_i(peer_flag_i),
      .retain_flag_i(retain_flag_i), .maker_code_i(maker_code_i), .rsp_valid_i(rsp_valid_i), .rsp_i(rsp_i),
      .req_valid_o(req_valid_o), .req_o(req_o), .notify_valid_o(notify_valid_o), .notify_o(notify_o),
      .err_o(err_o), .discard_o(discard_o), .busy_o(busy_o));

   equip_model partner (
      .mclk_i(mclk_i), .srst_i(srst_i), .dly_i(m_dly), .kind_i(m_kind), .fail_n_i(m_fail),
      .last_seq_i(m_last), .sw_same_i(m_sw), .env_i(m_env), .size_i(m_size), .maker_i(m_maker),
      .req_valid_i(req_valid_o), .req_i(req_o), .rsp_valid_o(rsp_valid_i), .rsp_o(rsp_i));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One download: reset, configure partner, start, follow to the notification
   task automatic run(input logic w, input logic sw, input logic [7:0] env, input logic [15:0] size,
                      input logic mbad, input logic [2:0] k, input logic [2:0] f, input logic [7:0] last,
                      input int reqs, input logic ok, input logic disc);
      int   n;
      int   first;
      int   nreq;
      int   ef;
      logic dseen;
      n = 0;
      first = 0;
      nreq = 0;
      dseen = 1'b0;
      @(posedge mclk_i);
      #10;
      srst_i = 1'b1;
      repeat (2) @(posedge mclk_i);
      #10;
      srst_i = 1'b0;
      // One flag alone must not trigger the transition wait
      {peer_flag_i, retain_flag_i} = w ? 2'h3 : {seed[12], ~seed[12]};
      {m_sw, m_env, m_size, m_kind, m_fail, m_last} = {sw, env, size, k, f, last};
      m_maker = mbad ? ~maker_code_i : maker_code_i;
      start_i = 1'b1;
      @(posedge mclk_i);
      #10;
      start_i = 1'b0;
      while (n < 2000 && notify_valid_o !== 1'b1) begin
         @(posedge mclk_i);
         #10;
         n++;
         if (req_valid_o === 1'b1) begin
            nreq++;
            if (first == 0) first = n;
            ef = (nreq - 1) / (((f > 3) ? 3 : f) + 1);
            check("request seq", ef, req_o.seq);
            check("frame number", ef + 1, req_o.frame_number);
         end
         check("busy while running", 1, busy_o);
         dseen |= (discard_o === 1'b1);
         seed = xs(seed);
         m_dly = {1'b0, seed[2:0]} + 4'h1;
      end
      check("notify pulse", 1, notify_valid_o);
      check("first request cycle", w ? TRANS + 2 : 1, first);
      check("request count", reqs, nreq);
      check("result", ok ? `RES_OK : `RES_FAIL, notify_o.first_payload_byte);
      check("length", `NOTIFY_LEN, notify_o.length);
      check("command", `CMD_NOTIFY, notify_o.command_code);
      check("error flag", !ok, err_o);
      check("discard", disc, dseen);
      @(posedge mclk_i);
      #10;
      check("busy", 0, busy_o);
   endtask

   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         print_verdict();
      end
   end

   initial begin
      repeat (12) @(posedge mclk_i);
      #10;
      srst_i = 1'b0;
      run(0, 1, 8'h00, {6'h0, seed[9:0]}, 0, 3'h0, 3'h0, 8'h03, 2, 1, 0);
      run(1, 0, 8'h00, 16'h0400, 0, 3'h0, 3'h0, 8'h04, 5, 1, 0);
      run(0, 0, 8'h00, {6'h0, seed[9:0]}, 0, 3'h1, 3'h3, 8'h03, 16, 1, 0);
      run(0, 0, 8'h00, {6'h0, seed[9:0]}, 0, 3'h2, 3'h4, 8'h03, 4, 0, 0);
      run(0, 0, 8'h00, {6'h0, seed[9:0]}, 0, 3'h3, 3'h3, 8'h02, 12, 1, 0);
      run(0, 0, 8'h00, {6'h0, seed[9:0]}, 0, 3'h3, 3'h4, 8'h02, 4, 0, 0);
      run(0, 0, 8'h00, {6'h0, seed[9:0]}, 0, 3'h4, 3'h0, 8'h03, 4, 1, 0);
      run(0, 0, 8'h00, 16'h0401, 0, 3'h0, 3'h0, 8'h03, 1, 0, 1);
      run(0, 0, 8'h00, {6'h0, seed[9:0]}, 1, 3'h0, 3'h0, 8'h03, 1, 0, 1);
      run(0, 1, 8'h05, {6'h0, seed[9:0]}, 0, 3'h0, 3'h0, 8'h03, 2, 0, 1);
      print_verdict();
   end
endmodule // program_download_sequencer_tb
